// ===== qdbsp_port.sv
/*
 * Device side of a separate-I/O, double-data-rate, burst-of-four SRAM:
 * command decode, write beat capture, masked array write through a
 * buffer, read burst output, termination and impedance stepping.
 * Assumes every sys_clk edge is one half-cycle: the first edge after
 * reset release is a K rise, then K-bar rise, alternating. All inputs
 * are synchronous to sys_clk.
 */
`timescale 1ns/1ps
module qdbsp_port
    import qdbsp_pkg::*;
#(
    parameter int DATA_W = DATA_W_DEF,
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int CAL_PERIOD = CAL_PERIOD_CYC,
    parameter int BUF_DEPTH = FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] sync_address_in,
    input wire logic read_select_n,
    input wire logic write_select_n,
    input wire logic [DATA_W-1:0] write_data_in,
    input wire logic [((DATA_W == NYB_DATA_W) ? 1 : DATA_W / BYTE_LANE_W)-1:0] byte_write_mask_n,
    input wire logic [NYB_MASK_W-1:0] nybble_write_mask_n,
    input wire logic termination_enable_in,
    input wire logic dll_off_n,
    input wire logic [1:0] drive_cmp_in,
    input wire logic [1:0] term_cmp_in,
    output logic [DATA_W-1:0] read_data_out,
    output logic read_valid_out,
    output logic echo_clock_out,
    output logic write_refused_out,
    output logic termination_active_out,
    output logic dll_enable_out,
    output logic [CODE_W-1:0] drive_code_out,
    output logic [CODE_W-1:0] term_code_out
);
    import qdbsp_pkg::*;

    // ------------------------------------------------------------
    // Derived widths
    // ------------------------------------------------------------
    localparam int LANE_W = (DATA_W == NYB_DATA_W) ? NYB_LANE_W : BYTE_LANE_W;
    localparam int MASK_W = DATA_W / LANE_W;
    localparam int WORD_W = BEATS * DATA_W;
    localparam int WMASK_W = BEATS * MASK_W;
    localparam int ENTRY_W = ADDR_W + WORD_W + WMASK_W;
    localparam int LVL_W = $clog2(BUF_DEPTH + 1);

    generate
        if (DATA_W % LANE_W != 0 || ADDR_W < 1 || ADDR_W > 24) begin : g_bad_geom
            $error("qdbsp_port: DATA_W must split into whole lanes, ADDR_W 1..24");
        end
    endgenerate

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    qdbsp_phase_type phase, next_phase;
    logic prev_read, next_prev_read;
    logic prev_write, next_prev_write;
    logic [WR_SR_LEN-1:0] wr_sr, next_wr_sr;
    logic [RD_SR_LEN-1:0] rd_sr, next_rd_sr;
    logic [ADDR_W-1:0] wr_addr [0:WR_SR_LEN-1];
    logic [ADDR_W-1:0] next_wr_addr [0:WR_SR_LEN-1];
    logic [ADDR_W-1:0] rd_addr [0:RD_FETCH_STAGE];
    logic [ADDR_W-1:0] next_rd_addr [0:RD_FETCH_STAGE];
    logic [WORD_W-1:0] asm_data, next_asm_data;
    logic [WMASK_W-1:0] asm_mask, next_asm_mask;
    logic [WORD_W-1:0] rd_word, next_rd_word;
    logic [DATA_W-1:0] next_read_data;
    logic next_read_valid, next_refused;
    logic [MASK_W-1:0] lane_mask_n;
    logic k_edge, rd_accept, wr_accept, wr_room, fetch;
    logic buf_in_ready, buf_out_valid, buf_out_ready;
    logic [ENTRY_W-1:0] buf_out_data;
    logic [LVL_W-1:0] buf_level;
    logic [WORD_W-1:0] mem_array [0:(1 << ADDR_W)-1];
    logic [ADDR_W-1:0] drain_addr;
    logic [WORD_W-1:0] drain_data;
    logic [WMASK_W-1:0] drain_mask;

    // ------------------------------------------------------------
    // Mask source: nybble masks on the 8-bit part, byte masks else
    // ------------------------------------------------------------
    generate
        if (DATA_W == NYB_DATA_W) begin : g_nyb
            assign lane_mask_n = nybble_write_mask_n;
        end else begin : g_byte
            assign lane_mask_n = byte_write_mask_n;
        end
    endgenerate

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    // Room is reserved for the write still in flight, so an accepted
    // write can never meet a full buffer when its beats complete.
    assign wr_room = buf_in_ready && (buf_level <= LVL_W'(BUF_DEPTH - FIFO_SLACK));
    assign k_edge = (phase == QDBSP_PH_K);
    // Read wins whenever read-select is low; a high one is a deselect
    assign rd_accept = k_edge && !read_select_n && !prev_read;
    // Write needs read-select high, so both high starts nothing
    assign wr_accept = k_edge && !write_select_n && read_select_n
                       && !prev_write && wr_room;
    // The array port serves the read fetch first; the buffer waits
    assign fetch = rd_sr[RD_FETCH_STAGE];
    assign buf_out_ready = !fetch;

    // Phase and previous-command flags
    always_comb begin
        case (phase)
            QDBSP_PH_K: next_phase = QDBSP_PH_KBAR;
            QDBSP_PH_KBAR: next_phase = QDBSP_PH_K;
            default: next_phase = QDBSP_PH_K;
        endcase
        next_prev_read = k_edge ? rd_accept : prev_read;
        next_prev_write = k_edge ? wr_accept : prev_write;
        next_refused = k_edge && !write_select_n && read_select_n
                       && !prev_write && !wr_room;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            phase <= QDBSP_PH_K;
            prev_read <= 1'b0;
            prev_write <= 1'b0;
            write_refused_out <= 1'b0;
        end else begin
            phase <= next_phase;
            prev_read <= next_prev_read;
            prev_write <= next_prev_write;
            write_refused_out <= next_refused;
        end
    end

    // ------------------------------------------------------------
    // Burst pipelines: one bit per stage, address carried alongside
    // ------------------------------------------------------------
    always_comb begin
        next_wr_sr = {wr_sr[WR_SR_LEN-2:0], wr_accept};
        next_rd_sr = {rd_sr[RD_SR_LEN-2:0], rd_accept};
        next_wr_addr[0] = sync_address_in;
        for (int i = 1; i < WR_SR_LEN; i++) begin
            next_wr_addr[i] = wr_addr[i-1];
        end
        next_rd_addr[0] = sync_address_in;
        for (int i = 1; i <= RD_FETCH_STAGE; i++) begin
            next_rd_addr[i] = rd_addr[i-1];
        end
    end

    // Address stages need no reset: the valid bits guard them
    always_ff @(posedge sys_clk) begin
        wr_addr <= next_wr_addr;
        rd_addr <= next_rd_addr;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wr_sr <= '0;
            rd_sr <= '0;
        end else begin
            wr_sr <= next_wr_sr;
            rd_sr <= next_rd_sr;
        end
    end

    // ------------------------------------------------------------
    // Write beat capture, data and masks on the same edge
    // ------------------------------------------------------------
    always_comb begin
        next_asm_data = asm_data;
        next_asm_mask = asm_mask;
        for (int b = 0; b < BEATS; b++) begin
            if (wr_sr[WR_BEAT0_STAGE + b]) begin
                next_asm_data[b*DATA_W +: DATA_W] = write_data_in;
                next_asm_mask[b*MASK_W +: MASK_W] = lane_mask_n;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            asm_data <= '0;
            asm_mask <= '1;
        end else begin
            asm_data <= next_asm_data;
            asm_mask <= next_asm_mask;
        end
    end

    // ------------------------------------------------------------
    // Write buffer between beat capture and the array
    // ------------------------------------------------------------
    qdbsp_fifo #(
        .W(ENTRY_W),
        .DEPTH(BUF_DEPTH)
    ) u_wbuf (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .in_valid(wr_sr[WR_PUSH_STAGE]),
        .in_ready(buf_in_ready),
        .in_data({wr_addr[WR_PUSH_STAGE], asm_mask, asm_data}),
        .out_valid(buf_out_valid),
        .out_ready(buf_out_ready),
        .out_data(buf_out_data),
        .level(buf_level)
    );

    assign drain_data = buf_out_data[WORD_W-1:0];
    assign drain_mask = buf_out_data[WORD_W +: WMASK_W];
    assign drain_addr = buf_out_data[ENTRY_W-1 -: ADDR_W];

    // Lane-wise array write; a masked lane keeps its old contents
    always_ff @(posedge sys_clk) begin
        if (buf_out_valid && buf_out_ready) begin
            for (int b = 0; b < BEATS; b++) begin
                for (int l = 0; l < MASK_W; l++) begin
                    if (!drain_mask[b*MASK_W + l]) begin
                        mem_array[drain_addr][b*DATA_W + l*LANE_W +: LANE_W]
                            <= drain_data[b*DATA_W + l*LANE_W +: LANE_W];
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Read fetch and beat output
    // ------------------------------------------------------------
    // Writes still in the buffer are not seen by a read of the same
    // address; the host must space such accesses.
    always_comb begin
        next_rd_word = fetch ? mem_array[rd_addr[RD_FETCH_STAGE]] : rd_word;
        next_read_data = read_data_out;
        next_read_valid = 1'b0;
        for (int b = 0; b < BEATS; b++) begin
            if (rd_sr[RD_BEAT0_STAGE + b]) begin
                next_read_data = rd_word[b*DATA_W +: DATA_W];
                next_read_valid = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rd_word <= '0;
            read_data_out <= '0;
            read_valid_out <= 1'b0;
        end else begin
            rd_word <= next_rd_word;
            read_data_out <= next_read_data;
            read_valid_out <= next_read_valid;
        end
    end

    // ------------------------------------------------------------
    // Echo clock, termination and DLL control
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            echo_clock_out <= 1'b0;
            termination_active_out <= 1'b0;
            dll_enable_out <= 1'b0;
        end else begin
            echo_clock_out <= k_edge; // High in the half-cycle after K rise
            termination_active_out <= termination_enable_in;
            dll_enable_out <= dll_off_n;
        end
    end

    // ------------------------------------------------------------
    // Impedance stepping for driver and termination
    // ------------------------------------------------------------
    qdbsp_zcal #(
        .PERIOD(CAL_PERIOD)
    ) u_drive_cal (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .cmp_raise(drive_cmp_in[1]),
        .cmp_lower(drive_cmp_in[0]),
        .code(drive_code_out)
    );

    qdbsp_zcal #(
        .PERIOD(CAL_PERIOD)
    ) u_term_cal (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .cmp_raise(term_cmp_in[1]),
        .cmp_lower(term_cmp_in[0]),
        .code(term_code_out)
    );

endmodule : qdbsp_port

// ===== qdbsp_pkg.sv
/*
 * Shared constants of the burst-of-four DDR SRAM port: beat stages,
 * lane widths, buffer depth and calibration timing.
 * Assumes a single 125 MHz system clock in which every edge is one
 * half-cycle of the memory command clock.
 */
package qdbsp_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int DATA_W_DEF = 18;
    localparam int ADDR_W_DEF = 19;
    localparam int BEATS = 4;
    localparam int BYTE_LANE_W = 9;
    localparam int NYB_LANE_W = 4;
    localparam int NYB_DATA_W = 8;
    localparam int NYB_MASK_W = 2;

    // ------------------------------------------------------------
    // Pipeline stages, counted in system clock edges after the
    // command edge (stage k is high between edge c+k and c+k+1)
    // ------------------------------------------------------------
    localparam int WR_BEAT0_STAGE = 1;
    localparam int WR_PUSH_STAGE = 5;
    localparam int WR_SR_LEN = 6;
    localparam int RD_FETCH_STAGE = 3;
    localparam int RD_BEAT0_STAGE = 4;
    localparam int RD_SR_LEN = 8;

    // ------------------------------------------------------------
    // Write buffer and calibration
    // ------------------------------------------------------------
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_SLACK = 2;
    localparam int CLK_PERIOD_NS = 8;
    localparam int CAL_PERIOD_NS = 8192;
    localparam int CAL_PERIOD_CYC = CAL_PERIOD_NS / CLK_PERIOD_NS;
    localparam int CODE_W = 6;
    localparam logic [CODE_W-1:0] CODE_RESET = 6'h20;

    // Half-cycle phase of the command clock
    typedef enum logic {QDBSP_PH_K, QDBSP_PH_KBAR} qdbsp_phase_type;

endpackage : qdbsp_pkg

// ===== qdbsp_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides and a fill level.
 * Assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
module qdbsp_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int PW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH + 1);

    logic [W-1:0] store [0:DEPTH-1];
    logic [PW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
    logic [$clog2(DEPTH+1)-1:0] count, next_count;
    logic push, pop;

    generate
        if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
            $error("qdbsp_fifo: DEPTH must be a power of two, at least 2");
        end
    endgenerate

    // Honest full and empty straight from the count
    assign in_ready = (count != LW'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = store[rd_ptr];
    assign level = count;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointer and count next values
    always_comb begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // Storage carries no reset; only written entries are ever read
    always_ff @(posedge sys_clk) begin
        if (push) begin
            store[wr_ptr] <= in_data;
        end
    end

endmodule : qdbsp_fifo

// ===== qdbsp_zcal.sv
/*
 * Periodic impedance stepper: a cycle counter triggers an evaluation,
 * which moves a binary-weighted code one step toward the comparator.
 * Assumes the comparator inputs are synchronous to sys_clk.
 */
`timescale 1ns/1ps
module qdbsp_zcal
    import qdbsp_pkg::*;
#(
    parameter int PERIOD = CAL_PERIOD_CYC
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic cmp_raise,
    input wire logic cmp_lower,
    output logic [CODE_W-1:0] code
);
    localparam int CW = (PERIOD > 1) ? $clog2(PERIOD) : 1;

    logic [CW-1:0] cnt, next_cnt;
    logic [CODE_W-1:0] next_code;
    logic eval;

    generate
        if (PERIOD < 2) begin : g_bad_period
            $error("qdbsp_zcal: PERIOD must be at least 2");
        end
    endgenerate

    // Counter wraps and restarts after each trigger
    always_comb begin
        eval = (cnt == CW'(PERIOD - 1));
        next_cnt = eval ? '0 : cnt + 1'b1;
        next_code = code;
        // One step at most, saturating at both ends
        if (eval && cmp_raise && !cmp_lower && code != '1) begin
            next_code = code + 1'b1;
        end else if (eval && cmp_lower && !cmp_raise && code != '0) begin
            next_code = code - 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= '0;
            code <= CODE_RESET;
        end else begin
            cnt <= next_cnt;
            code <= next_code;
        end
    end

endmodule : qdbsp_zcal

// ===== qdbsp_port_properties.sv
/* Checker for qdbsp_port: command decode, read burst timing, control
   outputs and impedance stepping. Sees only top ports; bound below. */
`timescale 1ns/1ps
module qdbsp_port_properties
    import qdbsp_pkg::*;
#(
    parameter int CAL_PERIOD = CAL_PERIOD_CYC
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic read_select_n,
    input wire logic write_select_n,
    input wire logic write_refused_out,
    input wire logic read_valid_out,
    input wire logic echo_clock_out,
    input wire logic termination_enable_in,
    input wire logic termination_active_out,
    input wire logic dll_off_n,
    input wire logic dll_enable_out,
    input wire logic [CODE_W-1:0] drive_code_out,
    input wire logic [CODE_W-1:0] term_code_out
);
    logic last_rd;
    logic acc_rd;
    int cal_cnt;
    // Echo still low before an edge marks that edge as a K rise
    assign acc_rd = !echo_clock_out && !read_select_n && !last_rd;
    // Previous K command and the evaluation phase
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            last_rd <= 1'b0;
            cal_cnt <= 0;
        end else begin
            if (!echo_clock_out) last_rd <= acc_rd;
            cal_cnt <= (cal_cnt == CAL_PERIOD - 1) ? 0 : cal_cnt + 1;
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    a_read_burst: assert property (
        acc_rd |-> ##6 read_valid_out [*4]) else $error("read burst not four beats");
    a_valid_cause: assert property (
        read_valid_out |-> $past(acc_rd, 6) || $past(acc_rd, 7) || $past(acc_rd, 8)
        || $past(acc_rd, 9)) else $error("read valid without an accepted read");
    a_echo_toggle: assert property (
        1'b1 |=> echo_clock_out != $past(echo_clock_out)) else $error("echo not toggling");
    a_term_follow: assert property (
        $past(nrst) |-> termination_active_out == $past(termination_enable_in))
        else $error("termination does not follow its enable");
    a_dll_follow: assert property (
        $past(nrst) |-> dll_enable_out == $past(dll_off_n)) else $error("dll enable wrong");
    a_drive_step: assert property (
        $changed(drive_code_out) |-> drive_code_out == $past(drive_code_out) + 6'h01
        || drive_code_out == $past(drive_code_out) - 6'h01) else $error("drive step not one");
    a_term_step: assert property (
        $changed(term_code_out) |-> term_code_out == $past(term_code_out) + 6'h01
        || term_code_out == $past(term_code_out) - 6'h01) else $error("term step not one");
    a_cal_period: assert property (
        ($changed(drive_code_out) || $changed(term_code_out)) |-> cal_cnt == 0)
        else $error("code moved off the evaluation edge");
    a_refuse_cause: assert property (
        write_refused_out |-> $past(!echo_clock_out && !write_select_n && read_select_n))
        else $error("write refused without a write command");
    c_read: cover property (acc_rd);
    c_write: cover property (!echo_clock_out && !write_select_n && read_select_n);
    c_cal: cover property ($changed(drive_code_out));
endmodule : qdbsp_port_properties

bind qdbsp_port qdbsp_port_properties #(.CAL_PERIOD(CAL_PERIOD)) u_props (
    .sys_clk, .nrst, .read_select_n, .write_select_n, .write_refused_out, .read_valid_out,
    .echo_clock_out,
    .termination_enable_in, .termination_active_out, .dll_off_n, .dll_enable_out,
    .drive_code_out, .term_code_out);

// ===== qdbsp_host.sv
/* Host controller model: commands on K rises, four write beats with
   masks after a write when bt is set. Assumes the first rise after reset is K. */
`timescale 1ns/1ps
module qdbsp_host (
    input wire logic sys_clk,
    input wire logic nrst,
    output logic [5:0] addr,
    output logic rd_n,
    output logic wr_n,
    output logic [17:0] wdata,
    output logic [1:0] mask_n,
    output logic [1:0] nyb_n
);
    logic k_next;
    // Which rise comes next; commands only go out ahead of a K rise
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) k_next <= 1'b1;
        else k_next <= ~k_next;
    end
    // Idle levels: selects high, never left floating
    initial begin
        addr = 6'h00;
        rd_n = 1'b1;
        wr_n = 1'b1;
        wdata = 18'h2a5a5;
        mask_n = 2'h3;
        nyb_n = 2'h3;
    end
    // One command; write beats follow in the background
    task automatic kcmd(input logic r, input logic w, input logic [5:0] a,
                        input logic [71:0] d, input logic [7:0] m, input bit bt);
        @(negedge sys_clk);
        while (!k_next) @(negedge sys_clk);
        rd_n = r;
        wr_n = w;
        addr = a;
        @(negedge sys_clk);
        rd_n = 1'b1;
        wr_n = 1'b1;
        addr = ~a; // Released address does not hold its value
        if (bt) begin
            fork
                begin
                    for (int b = 0; b < 4; b++) begin
                        @(negedge sys_clk);
                        wdata = d[b*18 +: 18];
                        mask_n = m[b*2 +: 2];
                    end
                    @(negedge sys_clk);
                    wdata = ~wdata;
                    mask_n = ~mask_n;
                end
            join_none
        end
    endtask : kcmd
endmodule : qdbsp_host

// ===== qdbsp_port_tb.sv
/* Self-checking bench for qdbsp_port driven by the host model.
   Assumes a 6-bit address and a short calibration period. */
`timescale 1ns/1ps
module qdbsp_port_tb;
    import qdbsp_pkg::*;
    localparam int CALP = 8;
    localparam logic [71:0] D1 = 72'h123456789abcdef012;
    localparam logic [71:0] D2 = 72'hfedcba987654321edc;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [5:0] addr;
    logic rd_n;
    logic wr_n;
    logic [17:0] wdata;
    logic [17:0] rdata;
    logic [1:0] mask_n;
    logic [1:0] nyb_n;
    logic term_en = 1'b0;
    logic dll_off_n = 1'b1;
    logic [1:0] dcmp = 2'h0;
    logic [1:0] tcmp = 2'h0;
    logic rvalid;
    logic refused;
    logic tact;
    logic dlle;
    logic [5:0] dcode;
    logic [5:0] tcode;
    logic [71:0] a1;
    int fails = 0;
    int n_compared = 0;

    always #4 sys_clk = ~sys_clk;

    qdbsp_host host (.sys_clk, .nrst, .addr, .rd_n, .wr_n, .wdata, .mask_n, .nyb_n);
    qdbsp_port #(.ADDR_W(6), .CAL_PERIOD(CALP)) dut (
        .sys_clk, .nrst, .sync_address_in(addr), .read_select_n(rd_n),
        .write_select_n(wr_n), .write_data_in(wdata), .byte_write_mask_n(mask_n),
        .nybble_write_mask_n(nyb_n), .termination_enable_in(term_en), .dll_off_n,
        .drive_cmp_in(dcmp), .term_cmp_in(tcmp), .read_data_out(rdata),
        .read_valid_out(rvalid), .echo_clock_out(), .write_refused_out(refused),
        .termination_active_out(tact), .dll_enable_out(dlle), .drive_code_out(dcode),
        .term_code_out(tcode));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One burst beat by beat, then the idle cycle after it
    task automatic burst(input int lead, input logic [71:0] exp);
        repeat (lead) @(negedge sys_clk);
        for (int b = 0; b < 4; b++) begin
            @(negedge sys_clk);
            chk(18'(rvalid), 18'h00001);
            chk(rdata, exp[b*18 +: 18]);
        end
        @(negedge sys_clk);
        chk(18'(rvalid), 18'h00000);
    endtask : burst
    // Write, then let the buffer drain before anything reads it back
    task automatic wr(input logic [5:0] a, input logic [71:0] d, input logic [7:0] m);
        host.kcmd(1'b1, 1'b0, a, d, m, 1'b1);
        chk(18'(refused), 18'h00000);
        repeat (24) @(negedge sys_clk);
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [71:0] exp);
        host.kcmd(1'b0, 1'b1, a, 72'h0, 8'hff, 1'b0);
        burst(4, exp);
    endtask : rd

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_full();
        wr(6'h01, D1, 8'h00);
        a1 = D1;
        rd(6'h01, a1);
    endtask : t_full
    // Per-beat lane masks over known data
    task automatic t_mask();
        logic [7:0] m;
        m = 8'h46;
        wr(6'h01, D2, m);
        for (int i = 0; i < 8; i++) a1[i*9 +: 9] = m[i] ? D1[i*9 +: 9] : D2[i*9 +: 9];
        rd(6'h01, a1);
    endtask : t_mask
    // Second read on the very next K rise must be dropped
    task automatic t_rr();
        host.kcmd(1'b0, 1'b1, 6'h01, 72'h0, 8'hff, 1'b0);
        host.kcmd(1'b0, 1'b1, 6'h02, 72'h0, 8'hff, 1'b0);
        burst(2, a1);
    endtask : t_rr
    // Deselect gives nothing; both selects low is a read, not a write
    task automatic t_desel();
        host.kcmd(1'b1, 1'b1, 6'h01, 72'h0, 8'hff, 1'b0);
        repeat (10) begin
            @(negedge sys_clk);
            chk(18'(rvalid), 18'h00000);
        end
        host.kcmd(1'b0, 1'b0, 6'h01, 72'h0, 8'h00, 1'b0);
        burst(4, a1);
        repeat (24) @(negedge sys_clk);
        rd(6'h01, a1);
    endtask : t_desel
    task automatic t_ww();
        host.kcmd(1'b1, 1'b0, 6'h02, D1, 8'h00, 1'b1);
        host.kcmd(1'b1, 1'b0, 6'h02, D2, 8'h00, 1'b0);
        repeat (24) @(negedge sys_clk);
        rd(6'h02, D1);
    endtask : t_ww
    // Write and read on consecutive K rises
    task automatic t_alt();
        host.kcmd(1'b1, 1'b0, 6'h03, D2, 8'h00, 1'b1);
        rd(6'h01, a1);
        repeat (24) @(negedge sys_clk);
        rd(6'h03, D2);
    endtask : t_alt
    task automatic t_ctrl();
        for (int i = 0; i < 4; i++) begin
            term_en = i[0];
            dll_off_n = i[1];
            @(negedge sys_clk);
            chk(18'(tact), 18'(i[0]));
            chk(18'(dlle), 18'(i[1]));
        end
    endtask : t_ctrl
    // Four evaluation periods with the comparators held steady
    task automatic t_cal();
        logic [5:0] d0;
        logic [5:0] t0;
        dcmp = 2'h2;
        tcmp = 2'h1;
        repeat (2) @(negedge sys_clk);
        d0 = dcode;
        t0 = tcode;
        repeat (4 * CALP) @(negedge sys_clk);
        chk(18'(dcode), 18'(d0 + 6'h04));
        chk(18'(tcode), 18'(t0 - 6'h04));
        dcmp = 2'h0;
        tcmp = 2'h0;
    endtask : t_cal

    task automatic end_of_test();
        $display("compared %0d, failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (5) @(negedge sys_clk);
        nrst = 1'b1;
        t_full();
        t_mask();
        t_rr();
        t_desel();
        t_ww();
        t_alt();
        t_ctrl();
        t_cal();
        end_of_test();
    end
    // Scenarios need well under a thousand cycles
    initial begin
        #20000;
        fails++;
        end_of_test();
    end
endmodule : qdbsp_port_tb
